// ### core/tick_pkg.sv
// constants and types shared by the periodic tick timer
package tick_pkg;

  // ==========================================================
  // widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W = 24;
  localparam int SEL_W = 4;
  localparam int RELOAD_BYTES = 3;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] RELOAD_OFS = 8'h04;
  localparam logic [7:0] CURRENT_OFS = 8'h08;

  // ==========================================================
  // control/status field positions
  localparam int ENABLE_BIT = 0;
  localparam int IRQ_EN_BIT = 1;
  localparam int SRC_BIT = 2;
  localparam int FLAG_BIT = 16;

  // ==========================================================
  // values after reset and fixed values
  localparam logic ENABLE_RST = 1'b0;
  localparam logic IRQ_EN_RST = 1'b0;
  localparam logic FLAG_RST = 1'b0;
  localparam logic SRC_CORE_CLK = 1'b1;
  localparam logic [CNT_W-1:0] RELOAD_RST = 24'h000000;
  localparam logic [CNT_W-1:0] CNT_RST = 24'h000000;
  localparam logic [CNT_W-1:0] CNT_ONE = 24'h000001;
  localparam logic [DATA_W-1:0] RDATA_RST = 32'h00000000;

  // ==========================================================
  // bus front states
  typedef enum logic {WB_IDLE, WB_ACK} wb_state_t;

endpackage

// ### core/tick_wb_front.sv
// classic wishbone slave handshake for the tick timer registers
`timescale 1ns/1ns
`default_nettype none
module tick_wb_front
  import tick_pkg::*;
(
  // clock, reset, enable
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // bus request
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  // handshake
  output logic req_out,
  output logic ack_out
);

  // ==========================================================
  // state
  wb_state_t state;
  wb_state_t next_state;

  // a request is taken once; ack follows on the next edge
  assign req_out = ce_in && wb_cyc_in && wb_stb_in && (state == WB_IDLE);
  assign ack_out = (state == WB_ACK);

  always_comb begin
    next_state = state;
    case (state)
      WB_IDLE: begin
        if (req_out) begin
          next_state = WB_ACK;
        end
      end
      WB_ACK: begin
        next_state = WB_IDLE;
      end
      default: begin
        next_state = WB_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= WB_IDLE;
    end else if (ce_in) begin
      state <= next_state;
    end
  end

endmodule
`default_nettype wire

// ### core/periodic_tick_timer.sv
// 24-bit periodic down-counting tick timer with wishbone registers
//
// Function
// - flag bit 16 reads 1 if zero was reached since last read; read clears
// - debugger read clears the flag only when master type is 0
// - source select bit 2: 0 external reference, 1 core clock
// - no reference clock here, so source select is held at 1
// - interrupt enable clear: reaching zero raises no interrupt request
// - interrupt enable set: each count to zero pends the tick exception
// - enable bit 0 clear stops the counter
// - enabled: load reload, count down, flag, optional pend, reload, repeat
// - reload is 24 bits in 23:0; bits 31:24 read-only
// - reload value 0 accepted but gives no flag or interrupt
// - repeating period is reload plus one count clocks
// - current value read returns the counter at the access
// - any current value write clears counter and flag
// - only control/status, reload and current value registers exist
// - counter holds while the core is halted in debug
// - writing current value never triggers the tick exception
// - reload of zero stops the counter at the next wrap
//
// Local design decisions: the address map and register access over Wishbone.
`timescale 1ns/1ns
`default_nettype none
module periodic_tick_timer
  import tick_pkg::*;
(
  // clock, reset, enable
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // wishbone slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [ADDR_W-1:0] wb_adr_in,
  input wire logic [SEL_W-1:0] wb_sel_in,
  input wire logic [DATA_W-1:0] wb_dat_in,
  output logic [DATA_W-1:0] wb_dat_out,
  output logic wb_ack_out,
  // debug side
  input wire logic dbg_access_in,
  input wire logic debug_master_type_in,
  input wire logic core_halted_in,
  // to the interrupt controller
  output logic tick_irq_out
);

  // ==========================================================
  // bus front
  logic req;
  logic ack;

  tick_wb_front front (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .wb_cyc_in(wb_cyc_in),
    .wb_stb_in(wb_stb_in),
    .req_out(req),
    .ack_out(ack)
  );

  assign wb_ack_out = ack;

  // ==========================================================
  // state
  logic enable;
  logic irq_en;
  logic flag;
  logic irq;
  logic [CNT_W-1:0] reload;
  logic [CNT_W-1:0] cnt;
  logic [DATA_W-1:0] rdata;
  logic next_enable;
  logic next_irq_en;
  logic next_flag;
  logic next_irq;
  logic [CNT_W-1:0] next_reload;
  logic [CNT_W-1:0] next_cnt;
  logic [DATA_W-1:0] next_rdata;

  // ==========================================================
  // address decode
  logic hit_ctrl;
  logic hit_reload;
  logic hit_cur;
  logic wr_ctrl;
  logic rd_ctrl;
  logic wr_reload;
  logic wr_cur;
  logic flag_clr;
  logic count_step;
  logic hit_zero;
  logic [DATA_W-1:0] ctrl_word;

  assign hit_ctrl = (wb_adr_in == CTRL_OFS);
  assign hit_reload = (wb_adr_in == RELOAD_OFS);
  assign hit_cur = (wb_adr_in == CURRENT_OFS);
  assign wr_ctrl = req && wb_we_in && hit_ctrl;
  assign rd_ctrl = req && !wb_we_in && hit_ctrl;
  assign wr_reload = req && wb_we_in && hit_reload;
  assign wr_cur = req && wb_we_in && hit_cur;

  // application reads clear; debugger reads only with master type 0
  assign flag_clr = rd_ctrl && (!dbg_access_in || !debug_master_type_in);

  // halted core or disabled counter holds the count
  assign count_step = ce_in && enable && !core_halted_in && !wr_cur;

  // events only on the step from one to zero
  assign hit_zero = count_step && (cnt == CNT_ONE);

  // source select always reads as core clock
  always_comb begin
    ctrl_word = RDATA_RST;
    ctrl_word[ENABLE_BIT] = enable;
    ctrl_word[IRQ_EN_BIT] = irq_en;
    ctrl_word[SRC_BIT] = SRC_CORE_CLK;
    ctrl_word[FLAG_BIT] = flag;
  end

  // ==========================================================
  // reload byte lanes
  genvar lane;
  generate
    for (lane = 0; lane < RELOAD_BYTES; lane++) begin : g_lane
      // bits 31:24 have no storage, so writes there are dropped
      assign next_reload[8*lane +: 8] =
        (wr_reload && wb_sel_in[lane]) ? wb_dat_in[8*lane +: 8]
                                       : reload[8*lane +: 8];
    end
  endgenerate

  // ==========================================================
  // next values
  always_comb begin
    next_enable = enable;
    next_irq_en = irq_en;
    if (wr_ctrl && wb_sel_in[0]) begin
      next_enable = wb_dat_in[ENABLE_BIT];
      next_irq_en = wb_dat_in[IRQ_EN_BIT];
    end
  end

  always_comb begin
    next_cnt = cnt;
    if (wr_cur) begin
      next_cnt = CNT_RST;
    end else if (count_step) begin
      if (cnt == CNT_RST) begin
        // wrap; a zero reload keeps the counter parked at zero
        next_cnt = reload;
      end else begin
        next_cnt = cnt - CNT_ONE;
      end
    end
  end

  always_comb begin
    next_flag = flag;
    if (flag_clr || wr_cur) begin
      next_flag = 1'b0;
    end
    if (hit_zero) begin
      next_flag = 1'b1;
    end
    // one-cycle pend; a current value write blocks hit_zero
    next_irq = hit_zero && irq_en;
  end

  always_comb begin
    next_rdata = rdata;
    if (req) begin
      next_rdata = RDATA_RST;
      if (!wb_we_in) begin
        if (hit_ctrl) begin
          next_rdata = ctrl_word;
        end else if (hit_reload) begin
          next_rdata[CNT_W-1:0] = reload;
        end else if (hit_cur) begin
          next_rdata[CNT_W-1:0] = cnt;
        end
      end
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      enable <= ENABLE_RST;
      irq_en <= IRQ_EN_RST;
      flag <= FLAG_RST;
      irq <= 1'b0;
      reload <= RELOAD_RST;
      cnt <= CNT_RST;
      rdata <= RDATA_RST;
    end else if (ce_in) begin
      enable <= next_enable;
      irq_en <= next_irq_en;
      flag <= next_flag;
      irq <= next_irq;
      reload <= next_reload;
      cnt <= next_cnt;
      rdata <= next_rdata;
    end
  end

  assign wb_dat_out = rdata;
  assign tick_irq_out = irq;

  // ==========================================================
  // checks
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence s_zero_hit;
    ce_in && count_step && (cnt == CNT_ONE);
  endsequence

  sequence s_wrap;
    count_step && (cnt == CNT_RST) && (reload != CNT_RST);
  endsequence

  sequence s_app_read;
    rd_ctrl && !dbg_access_in && !hit_zero;
  endsequence

  sequence s_dbg_keep;
    rd_ctrl && dbg_access_in && debug_master_type_in && flag;
  endsequence

  AST_FLAG_SET: assert property (s_zero_hit |=> flag)
    else $error("flag not set on count to zero");

  AST_APP_READ_CLR: assert property (s_app_read |=> !flag)
    else $error("application read did not clear flag");

  AST_DBG_READ_KEEP: assert property (s_dbg_keep |=> flag)
    else $error("debugger read cleared flag with master type 1");

  AST_DBG_READ_CLR: assert property (
    rd_ctrl && dbg_access_in && !debug_master_type_in && !hit_zero
    |=> !flag)
    else $error("debugger read with master type 0 kept flag");

  AST_SRC_ONE: assert property (
    rd_ctrl |=> wb_ack_out && wb_dat_out[SRC_BIT])
    else $error("source select not read as core clock");

  AST_NO_IRQ_DIS: assert property (ce_in && !irq_en |=> !tick_irq_out)
    else $error("interrupt pended while disabled");

  AST_IRQ_PEND: assert property (s_zero_hit ##0 irq_en |=> tick_irq_out)
    else $error("tick exception not pended");

  AST_IRQ_CAUSE: assert property (
    $rose(tick_irq_out) |-> $past(cnt) == CNT_ONE && cnt == CNT_RST)
    else $error("pend without a step from one to zero");

  AST_HOLD_DIS: assert property (!enable && !wr_cur |=> $stable(cnt))
    else $error("counter moved while disabled");

  AST_HALT: assert property (core_halted_in && !wr_cur |=> $stable(cnt))
    else $error("counter moved while core halted");

  AST_WRAP: assert property (s_wrap |=> cnt == $past(reload))
    else $error("wrap did not load reload value");

  AST_ZERO_RELOAD: assert property (
    count_step && cnt == CNT_RST && reload == CNT_RST
    |=> cnt == CNT_RST && !tick_irq_out)
    else $error("zero reload did not stop counter");

  AST_CUR_READ: assert property (
    req && !wb_we_in && hit_cur
    |=> wb_dat_out == {8'h00, $past(cnt)})
    else $error("current value read mismatch");

  AST_CUR_WRITE: assert property (
    wr_cur |=> cnt == CNT_RST && !flag && !tick_irq_out)
    else $error("current value write did not clear");

  AST_RSV_ZERO: assert property (
    wb_ack_out |-> wb_dat_out[31:24] == 8'h00)
    else $error("reserved bits not zero");

  AST_ACK_ONE: assert property (req |=> wb_ack_out ##1 !wb_ack_out)
    else $error("ack not a single cycle");

endmodule
`default_nettype wire

// ### verification/tick_irq_sink.sv
// interrupt controller stand-in that counts pended tick exceptions
`timescale 1ns/1ns
`default_nettype none
module tick_irq_sink (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // tick request
  input wire logic tick_irq_in,
  // pended total
  output var int pend_cnt_out
);
  // ========================================
  // pend counter
  // no reference clock is supplied, so core clock only
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pend_cnt_out <= 0;
    end else if (tick_irq_in === 1'b1) begin
      pend_cnt_out <= pend_cnt_out + 1;
    end
  end
endmodule
`default_nettype wire

// ### verification/periodic_tick_timer_tb_top.sv
// self-checking bench for the periodic tick timer
`timescale 1ns/1ns
`default_nettype none
module periodic_tick_timer_tb_top
  import tick_pkg::*;
;
  logic clk, rst_n, cyc, stb, we, dbg, mtype, halt, ack, irq;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q1, q2;
  int error_cnt, samples_checked, pend, c0;
  // ========================================
  // clock, design, partner
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  periodic_tick_timer dut (.sys_clk_in(clk), .rst_n_in(rst_n),
    .ce_in(1'b1), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
    .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
    .wb_dat_out(rdat), .wb_ack_out(ack), .dbg_access_in(dbg),
    .debug_master_type_in(mtype), .core_halted_in(halt),
    .tick_irq_out(irq));
  tick_irq_sink nested_irq_controller_model (.sys_clk_in(clk), .rst_n_in(rst_n),
    .tick_irq_in(irq), .pend_cnt_out(pend));
  // ========================================
  // tasks
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    if (n >= 40) begin
      error_cnt++;
      $display("BAD ack expected 1 seen timeout");
      wrap_up();
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                    input string what);
    logic [31:0] q;
    xfer(1'b0, a, 32'h00000000, q);
    check(what, q, exp);
  endtask
  task automatic pulses(input int cycles, input int exp);
    c0 = pend;
    repeat (cycles) @(posedge clk);
    check("pend", 32'(pend - c0), 32'(exp));
  endtask
  // ========================================
  // main sequence
  initial begin
    {cyc, stb, we, dbg, mtype, halt} = 6'h00;
    adr = 8'h00;
    sel = 4'hF;
    wdat = 32'h00000000;
    error_cnt = 0;
    samples_checked = 0;
    rst_n = 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(CTRL_OFS, 32'h00000004, "ctrl rst");
    rd(RELOAD_OFS, 32'h00000000, "reload rst");
    rd(CURRENT_OFS, 32'h00000000, "current rst");
    wr(RELOAD_OFS, 32'hFFFFFFFF);
    rd(RELOAD_OFS, 32'h00FFFFFF, "reload mask");
    sel <= 4'h2;
    wr(RELOAD_OFS, 32'h00000000);
    wr(CTRL_OFS, 32'h00000003);
    sel <= 4'hF;
    rd(RELOAD_OFS, 32'h00FF00FF, "reload lane");
    rd(CTRL_OFS, 32'h00000004, "ctrl sel");
    wr(CTRL_OFS, 32'hFFFEFFF8);
    rd(CTRL_OFS, 32'h00000004, "ctrl mask");
    rd(8'h0C, 32'h00000000, "unmapped");
    $display("test registers done");
    wr(RELOAD_OFS, 32'h00000002);
    wr(CTRL_OFS, 32'h00000003);
    repeat (6) @(posedge clk);
    pulses(30, 10);
    rd(CTRL_OFS, 32'h00010007, "ctrl run");
    wr(CTRL_OFS, 32'h00000002);
    dbg <= 1'b1;
    mtype <= 1'b1;
    rd(CTRL_OFS, 32'h00010006, "dbg mt1 a");
    rd(CTRL_OFS, 32'h00010006, "dbg mt1 b");
    dbg <= 1'b0;
    c0 = pend;
    wr(CURRENT_OFS, 32'h00ABCDEF);
    rd(CTRL_OFS, 32'h00000006, "flag wclr");
    check("wr pend", 32'(pend - c0), 32'h00000000);
    rd(CURRENT_OFS, 32'h00000000, "cur wclr");
    repeat (10) @(posedge clk);
    rd(CURRENT_OFS, 32'h00000000, "cur off");
    $display("test periodic done");
    wr(CTRL_OFS, 32'h00000001);
    pulses(30, 0);
    wr(CTRL_OFS, 32'h00000000);
    dbg <= 1'b1;
    mtype <= 1'b0;
    rd(CTRL_OFS, 32'h00010004, "dbg mt0 a");
    rd(CTRL_OFS, 32'h00000004, "dbg mt0 b");
    dbg <= 1'b0;
    $display("test polled done");
    wr(RELOAD_OFS, 32'h00000005);
    wr(CTRL_OFS, 32'h00000003);
    repeat (4) @(posedge clk);
    halt <= 1'b1;
    xfer(1'b0, CURRENT_OFS, 32'h00000000, q1);
    c0 = pend;
    repeat (12) @(posedge clk);
    xfer(1'b0, CURRENT_OFS, 32'h00000000, q2);
    check("halt hold", q2, q1);
    check("halt pend", 32'(pend - c0), 32'h00000000);
    halt <= 1'b0;
    c0 = pend;
    wr(CURRENT_OFS, 32'h00000001);
    rd(CTRL_OFS, 32'h00000007, "run wclr");
    check("run wr pend", 32'(pend - c0), 32'h00000000);
    $display("test halt done");
    wr(RELOAD_OFS, 32'h00000000);
    repeat (20) @(posedge clk);
    rd(CURRENT_OFS, 32'h00000000, "parked");
    rd(CTRL_OFS, 32'h00010007, "last wrap");
    pulses(20, 0);
    rd(CTRL_OFS, 32'h00000007, "no flag");
    $display("test reload zero done");
    wrap_up();
  end
endmodule
`default_nettype wire
